// ==== dio_pkg.sv ====
// Package of register map, field layout and constants for the 24-bit digital I/O block
package dio_pkg;

   // ==========================================================
   // Register byte offsets (one aligned 32-bit word each)
   localparam logic [7:0] off_p1_data = 8'h00;  // Port 1 logical data
   localparam logic [7:0] off_p2_data = 8'h04;  // Port 2 logical data
   localparam logic [7:0] off_p3_data = 8'h08;  // Port 3 logical data
   localparam logic [7:0] off_p1_sck  = 8'h0c;  // Port 1 set/clear/keep write
   localparam logic [7:0] off_p2_sck  = 8'h10;  // Port 2 set/clear/keep write
   localparam logic [7:0] off_p3_sck  = 8'h14;  // Port 3 set/clear/keep write
   localparam logic [7:0] off_pol     = 8'h18;  // Polarity, 24 bits
   localparam logic [7:0] off_ctrl    = 8'h1c;  // Direction and alternate functions
   localparam logic [7:0] off_cnt     = 8'h20;  // Counter value
   localparam logic [7:0] off_pwma_per = 8'h24; // PWM A period
   localparam logic [7:0] off_pwma_dut = 8'h28; // PWM A duty
   localparam logic [7:0] off_pwmb_per = 8'h2c; // PWM B period
   localparam logic [7:0] off_pwmb_dut = 8'h30; // PWM B duty

   // ==========================================================
   // Control register field positions
   localparam int ctrl_p1_out  = 0;  // Port 1 drives when set
   localparam int ctrl_p2_out  = 1;  // Port 2 drives when set
   localparam int ctrl_cnt_en  = 2;  // Port 2 bits 3/4 to the counter
   localparam int ctrl_cnt_gate = 3; // Gated mode when set, event mode when clear
   localparam int ctrl_pwm_en  = 4;  // Port 3 bits 0/1 to the PWMs
   localparam int ctrl_cnt_clr = 5;  // Write-one clears the counter
   localparam int ctrl_width   = 5;  // Stored control bits

   // ==========================================================
   // Bit positions and widths
   localparam int p2_cnt_clk_bit = 3; // Counter clock input
   localparam int p2_cnt_in_bit  = 4; // Counter (gate or event) input
   localparam int p3_pwm_b_bit   = 0; // PWM output B
   localparam int p3_pwm_a_bit   = 1; // PWM output A
   localparam int sck_clr_lsb    = 8; // Must-off mask in bits 15:8
   localparam int pwm_width      = 16;
   localparam int cnt_width      = 32;

   // ==========================================================
   // Reset values
   localparam logic [7:0]  port_rst = 8'h00;  // Inactive logical level
   localparam logic [23:0] pol_rst  = 24'h000000; // All active-high
   localparam logic [7:0]  p2_in_only = 8'h18; // Bits 3 and 4 never drive

   // AXI responses
   localparam logic [1:0] resp_okay   = 2'b00;
   localparam logic [1:0] resp_slverr = 2'b10;

   // Counter modes
   typedef enum logic {cnt_event, cnt_gated} cnt_mode_t;

endpackage : dio_pkg

// ==== dio_pwm.sv ====
// One PWM generator with programmable period and duty
`timescale 1ns/1ps
module dio_pwm
   import dio_pkg::*;
(
   // Clock and reset
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // Settings
   input  wire logic                 enable,
   input  wire logic [pwm_width-1:0] period,
   input  wire logic [pwm_width-1:0] duty,
   // Waveform, logical level
   output logic                      wave
);

   logic [pwm_width-1:0] count_q;  // Position in the period

   // ==========================================================
   // Period counter; wraps at period, so period+1 cycles per cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !enable || count_q >= period)
         count_q <= '0;
      else
         count_q <= count_q + 1'b1;
   end

   // Active while the count is below duty; duty above period gives steady high
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !enable)
         wave <= 1'b0;
      else
         wave <= (count_q < duty);
   end

   // Waveform stays low while disabled
   chk_pwm_idle_low: assert property (@(posedge aclk) disable iff (!aresetn)
      !enable |=> !wave) else $error("pwm active while disabled");

endmodule : dio_pwm

// ==== dio_counter.sv ====
// Event or gated counter fed by two logical inputs
`timescale 1ns/1ps
module dio_counter
   import dio_pkg::*;
(
   // Clock and reset
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // Control
   input  wire logic                 enable,
   input  wire cnt_mode_t            mode,
   input  wire logic                 clear,
   // Logical inputs (polarity already applied)
   input  wire logic                 cnt_clk,
   input  wire logic                 cnt_in,
   // Count
   output logic [cnt_width-1:0]      count
);

   logic clk_prev_q;  // Last counter clock level
   logic in_prev_q;   // Last counter input level
   logic tick;        // Qualifying event this cycle

   // ==========================================================
   // Edge memory
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         clk_prev_q <= 1'b0;
         in_prev_q  <= 1'b0;
      end
      else
      begin
         clk_prev_q <= cnt_clk;
         in_prev_q  <= cnt_in;
      end
   end

   // Event mode counts rising edges of the input; gated counts clock edges while gate active
   always_comb
   begin
      if (mode == cnt_event)
         tick = cnt_in && !in_prev_q;
      else
         tick = cnt_clk && !clk_prev_q && cnt_in;
   end

   // Clear wins over an arriving count so software sees a clean zero
   always_ff @(posedge aclk)
   begin
      if (!aresetn || clear)
         count <= '0;
      else if (enable && tick)
         count <= count + 1'b1;
   end

   chk_cnt_event_step: assert property (@(posedge aclk) disable iff (!aresetn)
      (enable && !clear && mode == cnt_event && cnt_in && !in_prev_q) |=> count == $past(count) + 1'b1)
      else $error("event count missed");
   chk_cnt_gate_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode == cnt_gated && !cnt_in && !clear) |=> count == $past(count))
      else $error("gated counter moved while gate inactive");

endmodule : dio_counter

// ==== dio_port24.sv ====
// Top level: three 8-bit ports with polarity, set/clear/keep writes, counter and PWMs over AXI4-Lite
//
// Behaviour
// - Port 1 direction chosen for whole byte
// - Port 2 bits 3 and 4 input only
// - Port 3 is output only
// - Every bit has its own polarity
// - Input read returns polarity-corrected pin values
// - Writes to input ports change nothing
// - Output write sets logical levels, pins follow polarity
// - Output read returns last written levels
// - Set/clear/keep and whole-port writes accepted
// - Port 2 bits 3/4 feed counter
// - Port 3 bit 1 PWM A, bit 0 B
// - Alternate-function bits leave general-purpose use
// - Two PWMs, independent period and duty
// - Event mode counts rising input edges
// - Gated mode counts clock while gate active
// - Polarity applies to alternate functions too
`timescale 1ns/1ps
module dio_port24
   import dio_pkg::*;
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Port 1 pins
   input  wire logic [7:0]  p1_in,
   output logic [7:0]       p1_out,
   output logic [7:0]       p1_oe,
   // Port 2 pins
   input  wire logic [7:0]  p2_in,
   output logic [7:0]       p2_out,
   output logic [7:0]       p2_oe,
   // Port 3 pins, output only
   output logic [7:0]       p3_out
);

   // ==========================================================
   // Storage
   logic [7:0]           p1_q, p2_q, p3_q;   // Logical output levels
   logic [23:0]          pol_q;              // 1 = active-low
   logic [ctrl_width-1:0] ctrl_q;            // Direction and alternates
   logic [pwm_width-1:0] pwma_per_q, pwma_dut_q, pwmb_per_q, pwmb_dut_q;
   logic [7:0]           aw_addr_q;          // Captured write address
   logic                 aw_have_q;          // Address held
   logic [31:0]          w_data_q;           // Captured write data
   logic [3:0]           w_strb_q;           // Captured strobes
   logic                 w_have_q;           // Data held
   logic                 cnt_clr_q;          // One-cycle counter clear
   logic [7:0]           p1_log_q, p2_log_q; // Logical input samples

   // Derived
   logic                 wr_fire;            // Both halves present, response free
   logic [7:0]           p2_gp_in;           // Port 2 inputs left for general use
   logic                 pwm_a, pwm_b;       // Logical PWM levels
   logic [cnt_width-1:0] cnt_val;            // Counter value
   logic                 p1_is_out, p2_is_out;

   assign p1_is_out = ctrl_q[ctrl_p1_out];
   assign p2_is_out = ctrl_q[ctrl_p2_out];
   assign wr_fire   = aw_have_q && w_have_q && !s_axi_bvalid;
   // Counter-owned bits read as zero whatever the port direction
   assign p2_gp_in  = p2_log_q & ~(ctrl_q[ctrl_cnt_en] ? p2_in_only : 8'h00);

   // Set/clear/keep merge: must-on wins over must-off when both are named
   function automatic logic [7:0] sck_merge(input logic [7:0] cur, input logic [31:0] d);
      sck_merge = (cur & ~d[sck_clr_lsb +: 8]) | d[7:0];
   endfunction : sck_merge

   // Byte-lane merge for 32-bit configuration words
   function automatic logic [31:0] lane_merge(input logic [31:0] cur, input logic [31:0] d,
                                              input logic [3:0] s);
      for (int i = 0; i < 4; i++)
         lane_merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : cur[i*8 +: 8];
   endfunction : lane_merge

   // ==========================================================
   // Write channel capture; address and data accepted in any order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h00000000;
         w_strb_q  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         else if (wr_fire)
            aw_have_q <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         else if (wr_fire)
            w_have_q <= 1'b0;
      end
   end

   // Ready pulses for one cycle when the slot is empty
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      end
   end

   // Write response; unmapped offsets answer SLVERR
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= resp_okay;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (aw_addr_q[1:0] == 2'b00 && aw_addr_q <= off_pwmb_dut) ? resp_okay : resp_slverr;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // ==========================================================
   // Port output levels; writes to a port set as input are dropped
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         p1_q <= port_rst;
         p2_q <= port_rst;
         p3_q <= port_rst;
      end
      else if (wr_fire && w_strb_q[0])
      begin
         case (aw_addr_q)
            off_p1_data: if (p1_is_out) p1_q <= w_data_q[7:0];
            off_p2_data: if (p2_is_out) p2_q <= w_data_q[7:0] & ~p2_in_only;
            off_p3_data: p3_q <= w_data_q[7:0];
            off_p1_sck:  if (p1_is_out) p1_q <= sck_merge(p1_q, w_data_q);
            off_p2_sck:  if (p2_is_out) p2_q <= sck_merge(p2_q, w_data_q) & ~p2_in_only;
            off_p3_sck:  p3_q <= sck_merge(p3_q, w_data_q);
            default:     p1_q <= p1_q;
         endcase
      end
   end

   // Configuration registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pol_q      <= pol_rst;
         ctrl_q     <= '0;
         pwma_per_q <= '0;
         pwma_dut_q <= '0;
         pwmb_per_q <= '0;
         pwmb_dut_q <= '0;
      end
      else if (wr_fire)
      begin
         case (aw_addr_q)
            // Size casts trim the merged word; a select on a call result is not legal
            off_pol:      pol_q <= 24'(lane_merge({8'h00, pol_q}, w_data_q, w_strb_q));
            off_ctrl:     if (w_strb_q[0]) ctrl_q <= w_data_q[ctrl_width-1:0];
            off_pwma_per: pwma_per_q <= pwm_width'(lane_merge({16'h0000, pwma_per_q}, w_data_q, w_strb_q));
            off_pwma_dut: pwma_dut_q <= pwm_width'(lane_merge({16'h0000, pwma_dut_q}, w_data_q, w_strb_q));
            off_pwmb_per: pwmb_per_q <= pwm_width'(lane_merge({16'h0000, pwmb_per_q}, w_data_q, w_strb_q));
            off_pwmb_dut: pwmb_dut_q <= pwm_width'(lane_merge({16'h0000, pwmb_dut_q}, w_data_q, w_strb_q));
            default:      pol_q <= pol_q;
         endcase
      end
   end

   // Counter clear strobe, one cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cnt_clr_q <= 1'b0;
      else
         cnt_clr_q <= wr_fire && w_strb_q[0] && aw_addr_q == off_ctrl && w_data_q[ctrl_cnt_clr];
   end

   // ==========================================================
   // Input sampling with polarity; pins treated as synchronous
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         p1_log_q <= 8'h00;
         p2_log_q <= 8'h00;
      end
      else
      begin
         p1_log_q <= p1_in ^ pol_q[7:0];
         p2_log_q <= p2_in ^ pol_q[15:8];
      end
   end

   // Alternate function engines, fed with logical levels
   dio_counter u_cnt (
      .aclk    (aclk),
      .aresetn (aresetn),
      .enable  (ctrl_q[ctrl_cnt_en]),
      .mode    (ctrl_q[ctrl_cnt_gate] ? cnt_gated : cnt_event),
      .clear   (cnt_clr_q),
      .cnt_clk (p2_log_q[p2_cnt_clk_bit]),
      .cnt_in  (p2_log_q[p2_cnt_in_bit]),
      .count   (cnt_val)
   );

   dio_pwm u_pwm_a (
      .aclk    (aclk),
      .aresetn (aresetn),
      .enable  (ctrl_q[ctrl_pwm_en]),
      .period  (pwma_per_q),
      .duty    (pwma_dut_q),
      .wave    (pwm_a)
   );

   dio_pwm u_pwm_b (
      .aclk    (aclk),
      .aresetn (aresetn),
      .enable  (ctrl_q[ctrl_pwm_en]),
      .period  (pwmb_per_q),
      .duty    (pwmb_dut_q),
      .wave    (pwm_b)
   );

   // ==========================================================
   // Pin drive: polarity applied, port 2 bits 3/4 never driven
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         p1_out <= pol_rst[7:0];
         p1_oe  <= 8'h00;
         p2_out <= pol_rst[15:8];
         p2_oe  <= 8'h00;
         p3_out <= pol_rst[23:16];
      end
      else
      begin
         p1_out <= p1_q ^ pol_q[7:0];
         p1_oe  <= {8{p1_is_out}};
         p2_out <= p2_q ^ pol_q[15:8];
         p2_oe  <= {8{p2_is_out}} & ~p2_in_only;
         p3_out <= p3_q ^ pol_q[23:16];
         if (ctrl_q[ctrl_pwm_en])
         begin
            // General output level ignored while the PWMs own the bits
            p3_out[p3_pwm_a_bit] <= pwm_a ^ pol_q[16 + p3_pwm_a_bit];
            p3_out[p3_pwm_b_bit] <= pwm_b ^ pol_q[16 + p3_pwm_b_bit];
         end
      end
   end

   // ==========================================================
   // Read path, one read at a time
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= resp_okay;
      end
      else if (s_axi_rvalid)
      begin
         s_axi_arready <= 1'b0;
         if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
      else if (s_axi_arvalid && !s_axi_arready)
         s_axi_arready <= 1'b1;
      else if (s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= resp_okay;
         case (s_axi_araddr)
            // Output ports read back written levels, inputs read live logic
            off_p1_data: s_axi_rdata <= {24'h0, p1_is_out ? p1_q : p1_log_q};
            off_p2_data: s_axi_rdata <= {24'h0, p2_is_out ? ((p2_q & ~p2_in_only) | (p2_gp_in & p2_in_only))
                                                      : p2_gp_in};
            off_p3_data: s_axi_rdata <= {24'h0, p3_q};
            off_p1_sck, off_p2_sck, off_p3_sck: s_axi_rdata <= 32'h00000000;
            off_pol:      s_axi_rdata <= {8'h00, pol_q};
            off_ctrl:     s_axi_rdata <= {27'h0, ctrl_q};
            off_cnt:      s_axi_rdata <= cnt_val;
            off_pwma_per: s_axi_rdata <= {16'h0, pwma_per_q};
            off_pwma_dut: s_axi_rdata <= {16'h0, pwma_dut_q};
            off_pwmb_per: s_axi_rdata <= {16'h0, pwmb_per_q};
            off_pwmb_dut: s_axi_rdata <= {16'h0, pwmb_dut_q};
            default:
            begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= resp_slverr;
            end
         endcase
      end
   end

   // ==========================================================
   // Checks
   sequence s_in_write;
      wr_fire && !p1_is_out && aw_addr_q == off_p1_data;
   endsequence
   chk_p1_byte_dir: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 (p1_oe == 8'h00 || p1_oe == 8'hff)) else $error("port 1 direction split");
   chk_p2_inonly: assert property (@(posedge aclk) disable iff (!aresetn)
      (p2_oe & p2_in_only) == 8'h00) else $error("port 2 input-only bit driven");
   chk_input_write_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
      s_in_write |=> p1_q == $past(p1_q)) else $error("write to input port stored");
   chk_p1_drive_pol: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 p1_out == $past(p1_q ^ pol_q[7:0])) else $error("port 1 pin level wrong");
   chk_pwm_a_route: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_q[ctrl_pwm_en] |=> p3_out[p3_pwm_a_bit] == $past(pwm_a ^ pol_q[16 + p3_pwm_a_bit]))
      else $error("pwm a not on port 3 bit 1");
   chk_sck_merge: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_fire && w_strb_q[0] && aw_addr_q == off_p3_sck) |=>
      p3_q == (($past(p3_q) & ~$past(w_data_q[15:8])) | $past(w_data_q[7:0]))) else $error("set/clear/keep wrong");
   chk_reset_defaults: assert property (@(posedge aclk)
      !aresetn |=> (ctrl_q == '0 && p3_q == 8'h00)) else $error("reset state wrong");
   chk_p3_write: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_fire && w_strb_q[0] && aw_addr_q == off_p3_data) |=> p3_q == $past(w_data_q[7:0]))
      else $error("port 3 write lost");

endmodule : dio_port24

// ==== dio_rack_model.sv ====
// Model of the signal-conditioning rack wired to the two bidirectional ports
`timescale 1ns/1ps
module dio_rack_model
(
   // Block pin drive
   input  wire logic [7:0] p1_out,
   input  wire logic [7:0] p1_oe,
   input  wire logic [7:0] p2_out,
   input  wire logic [7:0] p2_oe,
   // Levels the rack modules put on undriven lines
   input  wire logic [7:0] rack1,
   input  wire logic [7:0] rack2,
   // Resolved wire levels
   output logic [7:0]      p1_in,
   output logic [7:0]      p2_in
);
   // ==========================================
   // Wire resolution
   // A driven bit reads back its own drive; rack levels only show where the block lets go
   assign p1_in = (p1_out & p1_oe) | (rack1 & ~p1_oe);
   assign p2_in = (p2_out & p2_oe) | (rack2 & ~p2_oe);
endmodule : dio_rack_model

// ==== tb_top.sv ====
// Self-checking bench for the 24-bit digital I/O block
`timescale 1ns/1ps
module tb_top
   import dio_pkg::*;
;
   // ==========================================
   // Stimulus and observed signals
   logic        aclk = 0, aresetn = 0;
   logic [7:0]  awaddr = 0, araddr = 0, drv1 = 0, drv2 = 0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0, got, v, s, c, pol;
   logic [1:0]  resp;
   wire         awready, wready, bvalid, arready, rvalid;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [7:0]  p1_in, p1_out, p1_oe, p2_in, p2_out, p2_oe, p3_out;
   int          error_cnt = 0, tests_run = 0, cyc = 0, i, n, pa, pb, da, db, ha, hb;

   always #2 aclk = ~aclk;  // 250 MHz

   dio_port24 uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .p1_in(p1_in), .p1_out(p1_out),
      .p1_oe(p1_oe), .p2_in(p2_in), .p2_out(p2_out), .p2_oe(p2_oe), .p3_out(p3_out));
   dio_rack_model rack (.p1_out(p1_out), .p1_oe(p1_oe), .p2_out(p2_out), .p2_oe(p2_oe),
      .rack1(drv1), .rack2(drv2), .p1_in(p1_in), .p2_in(p2_in));

   // ==========================================
   // Shared tasks
   task tally_and_finish;
      $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] act);
      tests_run++;
      if (act !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, act);
      end
   endtask : chk

   // Write: both halves offered together, each dropped when taken
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic ad, wd;
      @(posedge aclk);
      ad = 0;
      wd = 0;
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      while (!(ad && wd))
      begin
         @(posedge aclk);
         if (!ad && awready === 1'b1) begin ad = 1; awvalid <= 0; end
         if (!wd && wready === 1'b1) begin wd = 1; wvalid <= 0; end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      resp = bresp;
      bready <= 0;
   endtask : wr

   task rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 0;
      while (rvalid !== 1'b1) @(posedge aclk);
      got = rdata;
      resp = rresp;
      rready <= 0;
   endtask : rd

   // Pin pulses on port 2, with settle time for the input sampling
   task pulse(input int b, input int k);
      repeat (k)
      begin
         @(posedge aclk); drv2[b] <= 1;
         repeat (2) @(posedge aclk);
         drv2[b] <= 0;
         @(posedge aclk);
      end
      repeat (3) @(posedge aclk);
   endtask : pulse

   // Hang guard, well above the expected run length
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin error_cnt++; tally_and_finish; end
   end

   // ==========================================
   // Main sequence
   initial
   begin
      v = $urandom(32'h9b5b);
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      chk("p1_oe", 0, p1_oe);
      chk("p2_oe", 0, p2_oe);
      chk("p3_out", 0, p3_out);
      pol = $urandom & 32'hffffff;
      wr(off_pol, pol);
      drv1 <= $urandom; drv2 <= $urandom;
      repeat (3) @(posedge aclk);
      rd(off_p1_data); chk("p1_in_read", drv1 ^ pol[7:0], got);
      wr(off_p1_data, 32'hff); wr(off_p1_sck, 32'hff); wr(off_ctrl, 1);
      rd(off_p1_data); chk("p1_input_write", 0, got);
      chk("p1_oe_out", 8'hff, p1_oe);
      $display("test input and reset done");
      for (i = 0; i < 4; i++)
      begin
         v = $urandom & 8'hff;
         wr(off_p1_data, v); rd(off_p1_data); chk("p1_read", v, got);
         chk("p1_pin", v ^ pol[7:0], p1_out);
         s = $urandom & 8'hff; c = (i == 0) ? s : $urandom & 8'hff;
         wr(off_p1_sck, {16'h0, c[7:0], s[7:0]});
         rd(off_p1_data); chk("p1_sck", (v & ~c | s) & 8'hff, got);
      end
      wr(off_ctrl, 3); v = $urandom & 8'hff; wr(off_p2_data, v);
      rd(off_p2_data); chk("p2_read", (v & 8'he7) | ((drv2 ^ pol[15:8]) & 8'h18), got);
      chk("p2_oe", 8'he7, p2_oe);
      chk("p2_pin", (v ^ pol[15:8]) & 8'he7, p2_out & 8'he7);
      v = $urandom & 8'hff; wr(off_p3_data, v); rd(off_p3_data); chk("p3_read", v, got);
      chk("p3_pin", v ^ pol[23:16], p3_out);
      $display("test output ports done");
      wr(off_pol, 0); drv2 <= 0; wr(off_ctrl, 32'h24); n = 3 + $urandom % 8;
      pulse(4, n); rd(off_cnt); chk("cnt_event", n, got);
      rd(off_p2_data); chk("p2_alt_bits", 0, got & 8'h18);
      wr(off_pol, 32'h1000); wr(off_ctrl, 32'h2c);
      pulse(3, n); drv2[4] <= 1; pulse(3, 5);
      rd(off_cnt); chk("cnt_gated", n, got);
      $display("test counter done");
      pa = 3 + $urandom % 6; da = 1 + $urandom % pa; pb = 3 + $urandom % 6; db = $urandom % pb;
      wr(off_pwma_per, pa); wr(off_pwma_dut, da); wr(off_pwmb_per, pb); wr(off_pwmb_dut, db);
      wr(off_ctrl, 32'h10); repeat (20) @(posedge aclk);
      ha = 0; hb = 0;
      repeat (2 * (pa + 1) * (pb + 1))
      begin
         @(posedge aclk);
         ha += (p3_out[p3_pwm_a_bit] === 1'b1);
         hb += (p3_out[p3_pwm_b_bit] === 1'b1);
      end
      chk("pwm_a_high", 2 * (pb + 1) * da, ha);
      chk("pwm_b_high", 2 * (pa + 1) * db, hb);
      chk("p3_gp_bits", v[7:2], p3_out[7:2]);
      wr(8'h40, 1); chk("bresp_unmapped", resp_slverr, resp);
      rd(8'h41); chk("rresp_unmapped", resp_slverr, resp);
      $display("test pwm and decode done");
      tally_and_finish;
   end
endmodule : tb_top
